// ==== src/clk_mode_defs.vh ====
// Offsets, field positions, reset values and timing counts of the clock block
`ifndef CLK_MODE_DEFS_VH
`define CLK_MODE_DEFS_VH

// Register byte addresses
`define ADDR_SYS_CLOCK_CTRL 8'h00
`define ADDR_FAST_OSC_CTRL 8'h04
`define ADDR_MODE_STATUS 8'h08

// System clock control fields
`define SCC_SEL_HI 7
`define SCC_SEL_LO 5
`define SCC_FAST_KEEP 1
`define SCC_SLOW_KEEP 0
`define SCC_RESET 8'h00

// Fast oscillator control fields
`define FOC_FREQ_HI 3
`define FOC_FREQ_LO 2
`define FOC_STABLE 1
`define FOC_ENABLE 0
`define FOC_RESET 8'h01

// Select code that picks the slow sub clock
`define SEL_SLOW_SUB 3'h7

// Operating mode codes
`define MODE_FAST 3'h0
`define MODE_SLOW 3'h1
`define MODE_SLEEP 3'h2
`define MODE_IDLE_SLOW_ONLY 3'h3
`define MODE_IDLE_BOTH_CLOCKS 3'h4
`define MODE_IDLE_FAST_ONLY 3'h5

// Fast oscillator settling time and clock period
`define FAST_OSC_SETTLE_NS 16000
`define ACLK_PERIOD_PS 4000
`define FAST_OSC_SETTLE_CYC \
   ((`FAST_OSC_SETTLE_NS * 1000 + `ACLK_PERIOD_PS - 1) / `ACLK_PERIOD_PS)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== src/fast_clock_divider.v ====
// Divider that turns fast clock edges into divide-by-1..64 ticks
`include "clk_mode_defs.vh"

module fast_clock_divider (
   input wire aclk,
   input wire aresetn,
   input wire fast_edge,
   input wire [2:0] ratio_sel,
   output reg div_tick
);

   reg [5:0] count_ff;
   wire [5:0] last_count;

   // Terminal count is two to the power of the select, minus one
   assign last_count = (6'h01 << ratio_sel) - 6'h01;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_ff <= 6'h00;
         div_tick <= 1'b0;
      end
      else
      begin
         div_tick <= 1'b0;
         if (fast_edge)
         begin
            if (count_ff >= last_count)
            begin
               count_ff <= 6'h00;
               div_tick <= 1'b1;
            end
            else
               count_ff <= count_ff + 6'h01;
         end
      end
   end

endmodule // fast_clock_divider

// ==== src/system_clock_and_power_modes.v ====
// Clock source, divider and power mode controller with AXI4-Lite registers
//
// What this block does
// - Six modes exist, fast and slow running and four halted ones.
// - In fast mode the system clock is the fast clock over 1 to 64.
// - Divided choices run from fast clock over 2 up to over 64.
// - Select code 111 gives slow mode on the slow sub clock.
// - The slow sub clock comes from the 32 kHz slow RC oscillator.
// - The fast RC oscillator runs at 4, 8 or 12 MHz by a 2-bit field.
// - In slow mode the fast oscillator follows its enable bit.
// - The oscillators also clock the watchdog and time base logic.
// - Halt with both keep bits low enters sleep, all clocks stopped.
// - In sleep the slow oscillator runs only if the watchdog is on.
// - Halt with fast keep 0, slow keep 1 keeps only the slow clock.
// - Halt with both keep bits high keeps both clocks running.
// - Halt with fast keep 1, slow keep 0 keeps only the fast clock.
// - Frequency field 00 is 4, 01 is 8, 10 is 12, 11 is 4 MHz.
// - The stable flag clears on enable or change, new freq on the same edge as set.
`include "clk_mode_defs.vh"

module system_clock_and_power_modes (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire halt_req,
   input wire wake_req,
   input wire wdt_enable,
   input wire fast_osc_tick_pin,
   input wire slow_osc_tick_pin,
   output reg fast_osc_run,
   output reg [1:0] fast_osc_trim_sel,
   output reg [3:0] fast_clock_mhz,
   output reg slow_osc_run,
   output reg cpu_clock_en,
   output reg system_clock_en,
   output reg system_tick,
   output reg fast_clock_en,
   output reg fast_clock_tick,
   output reg slow_sub_clock_en,
   output reg slow_sub_clock_tick,
   output reg wdt_clock_tick,
   output reg timebase_clock_tick,
   output reg [2:0] op_mode
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Frequency code to MHz
   function [3:0] freq_mhz;
      input [1:0] code;
      begin
         case (code)
            2'h1: freq_mhz = 4'h8;
            2'h2: freq_mhz = 4'hc;
            default: freq_mhz = 4'h4;
         endcase
      end
   endfunction

   // Halted mode chosen by the two keep bits
   function [2:0] halt_mode;
      input fast_keep;
      input slow_keep;
      begin
         case ({fast_keep, slow_keep})
            2'b01: halt_mode = `MODE_IDLE_SLOW_ONLY;
            2'b11: halt_mode = `MODE_IDLE_BOTH_CLOCKS;
            2'b10: halt_mode = `MODE_IDLE_FAST_ONLY;
            default: halt_mode = `MODE_SLEEP;
         endcase
      end
   endfunction

   localparam [31:0] SETTLE_LAST_FULL = `FAST_OSC_SETTLE_CYC - 1;
   localparam [11:0] SETTLE_LAST = SETTLE_LAST_FULL[11:0];
   localparam [7:0] SCC_RST = `SCC_RESET;
   localparam [7:0] FOC_RST = `FOC_RESET;

   // ----------------------------------------------------------------
   // Oscillator pin synchronisers
   // ----------------------------------------------------------------

   reg fast_s1_ff, fast_s2_ff, fast_s3_ff;
   reg slow_s1_ff, slow_s2_ff, slow_s3_ff;
   wire fast_edge;
   wire slow_edge;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fast_s1_ff <= 1'b0;
         fast_s2_ff <= 1'b0;
         fast_s3_ff <= 1'b0;
         slow_s1_ff <= 1'b0;
         slow_s2_ff <= 1'b0;
         slow_s3_ff <= 1'b0;
      end
      else
      begin
         fast_s1_ff <= fast_osc_tick_pin;
         fast_s2_ff <= fast_s1_ff;
         fast_s3_ff <= fast_s2_ff;
         slow_s1_ff <= slow_osc_tick_pin;
         slow_s2_ff <= slow_s1_ff;
         slow_s3_ff <= slow_s2_ff;
      end
   end

   assign fast_edge = fast_s2_ff & ~fast_s3_ff;
   assign slow_edge = slow_s2_ff & ~slow_s3_ff;

   // ----------------------------------------------------------------
   // Registers and AXI4-Lite slave
   // ----------------------------------------------------------------

   reg [2:0] sel_ff;
   reg fast_keep_ff;
   reg slow_keep_ff;
   reg [1:0] freq_sel_ff;
   reg osc_en_ff;
   reg stable_ff;
   reg aw_held_ff;
   reg w_held_ff;
   reg [7:0] aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg [2:0] mode_ff;
   wire do_write;
   wire scc_hit;
   wire foc_hit;
   reg [31:0] nxt_rdata;
   reg [1:0] nxt_rresp;

   assign awready = ~aw_held_ff & ~bvalid;
   assign wready = ~w_held_ff & ~bvalid;
   assign arready = ~rvalid;
   assign do_write = aw_held_ff & w_held_ff & ~bvalid;
   assign scc_hit = aw_addr_ff == `ADDR_SYS_CLOCK_CTRL;
   assign foc_hit = aw_addr_ff == `ADDR_FAST_OSC_CTRL;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         sel_ff <= SCC_RST[`SCC_SEL_HI:`SCC_SEL_LO];
         fast_keep_ff <= SCC_RST[`SCC_FAST_KEEP];
         slow_keep_ff <= SCC_RST[`SCC_SLOW_KEEP];
         freq_sel_ff <= FOC_RST[`FOC_FREQ_HI:`FOC_FREQ_LO];
         osc_en_ff <= FOC_RST[`FOC_ENABLE];
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held_ff <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
         end
         if (do_write)
         begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (scc_hit | foc_hit) ? `RESP_OKAY : `RESP_DECERR;
            if (scc_hit && w_strb_ff[0])
            begin
               sel_ff <= w_data_ff[`SCC_SEL_HI:`SCC_SEL_LO];
               fast_keep_ff <= w_data_ff[`SCC_FAST_KEEP];
               slow_keep_ff <= w_data_ff[`SCC_SLOW_KEEP];
            end
            if (foc_hit && w_strb_ff[0])
            begin
               freq_sel_ff <= w_data_ff[`FOC_FREQ_HI:`FOC_FREQ_LO];
               osc_en_ff <= w_data_ff[`FOC_ENABLE];
            end
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `RESP_OKAY;
      case (araddr)
         `ADDR_SYS_CLOCK_CTRL:
         begin
            nxt_rdata[`SCC_SEL_HI:`SCC_SEL_LO] = sel_ff;
            nxt_rdata[`SCC_FAST_KEEP] = fast_keep_ff;
            nxt_rdata[`SCC_SLOW_KEEP] = slow_keep_ff;
         end
         `ADDR_FAST_OSC_CTRL:
         begin
            nxt_rdata[`FOC_FREQ_HI:`FOC_FREQ_LO] = freq_sel_ff;
            nxt_rdata[`FOC_STABLE] = stable_ff;
            nxt_rdata[`FOC_ENABLE] = osc_en_ff;
         end
         `ADDR_MODE_STATUS:
            nxt_rdata[2:0] = mode_ff;
         default:
            nxt_rresp = `RESP_DECERR;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= nxt_rdata;
         rresp <= nxt_rresp;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Operating mode state
   // ----------------------------------------------------------------

   reg [2:0] nxt_mode;
   wire running;

   assign running = (mode_ff == `MODE_FAST) | (mode_ff == `MODE_SLOW);

   always @*
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         `MODE_FAST, `MODE_SLOW:
         begin
            // code 111 runs on the slow sub clock
            if (sel_ff == `SEL_SLOW_SUB)
               nxt_mode = `MODE_SLOW;
            else
               nxt_mode = `MODE_FAST;
            // keep bits pick the halted mode
            if (halt_req)
               nxt_mode = halt_mode(fast_keep_ff, slow_keep_ff);
         end
         `MODE_SLEEP, `MODE_IDLE_SLOW_ONLY, `MODE_IDLE_BOTH_CLOCKS,
         `MODE_IDLE_FAST_ONLY:
         begin
            if (wake_req)
               nxt_mode = (sel_ff == `SEL_SLOW_SUB) ? `MODE_SLOW
                                                   : `MODE_FAST;
         end
         default:
            nxt_mode = `MODE_FAST;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         mode_ff <= `MODE_FAST;
      else
         mode_ff <= nxt_mode;
   end

   // ----------------------------------------------------------------
   // Clock gating decisions
   // ----------------------------------------------------------------

   reg nxt_fast_on;
   reg nxt_slow_sub_on;
   reg nxt_slow_osc_on;
   reg nxt_sys_on;

   always @*
   begin
      nxt_fast_on = 1'b0;
      nxt_slow_sub_on = 1'b1;
      nxt_slow_osc_on = 1'b1;
      nxt_sys_on = 1'b0;
      case (mode_ff)
         `MODE_FAST:
         begin
            nxt_fast_on = 1'b1;
            nxt_sys_on = 1'b1;
         end
         `MODE_SLOW:
         begin
            // enable bit decides in slow mode
            nxt_fast_on = osc_en_ff;
            nxt_sys_on = 1'b1;
         end
         `MODE_SLEEP:
         begin
            nxt_slow_sub_on = 1'b0;
            nxt_slow_osc_on = wdt_enable;
         end
         `MODE_IDLE_SLOW_ONLY:
         begin
            // system clock only on the live source
            nxt_sys_on = sel_ff == `SEL_SLOW_SUB;
         end
         `MODE_IDLE_BOTH_CLOCKS:
         begin
            nxt_fast_on = 1'b1;
            nxt_sys_on = 1'b1;
         end
         `MODE_IDLE_FAST_ONLY:
         begin
            nxt_fast_on = 1'b1;
            nxt_slow_sub_on = 1'b0;
            // system clock only on the live source
            nxt_sys_on = sel_ff != `SEL_SLOW_SUB;
         end
         default:
         begin
            nxt_fast_on = 1'b1;
            nxt_sys_on = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Fast oscillator settling
   // ----------------------------------------------------------------

   reg [11:0] settle_cnt_ff;
   reg settling_ff;
   wire restart;

   // enable or frequency change restarts settling
   assign restart = (nxt_fast_on & ~fast_osc_run) |
                    (fast_osc_run & (freq_sel_ff != fast_osc_trim_sel));

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fast_osc_run <= 1'b0;
         fast_osc_trim_sel <= 2'h0;
         fast_clock_mhz <= 4'h4;
         settle_cnt_ff <= 12'h000;
         settling_ff <= 1'b0;
         stable_ff <= 1'b0;
      end
      else
      begin
         fast_osc_run <= nxt_fast_on;
         fast_osc_trim_sel <= freq_sel_ff;
         if (!nxt_fast_on)
         begin
            settling_ff <= 1'b0;
            stable_ff <= 1'b0;
         end
         else if (restart)
         begin
            settling_ff <= 1'b1;
            stable_ff <= 1'b0;
            settle_cnt_ff <= 12'h000;
         end
         else if (settling_ff)
         begin
            if (settle_cnt_ff == SETTLE_LAST)
            begin
               // flag set and new frequency applied on the same edge
               settling_ff <= 1'b0;
               stable_ff <= 1'b1;
               fast_clock_mhz <= freq_mhz(fast_osc_trim_sel);
            end
            else
               settle_cnt_ff <= settle_cnt_ff + 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock outputs and ticks
   // ----------------------------------------------------------------

   wire fast_live;
   wire div_tick;
   wire sys_src_tick;

   assign fast_live = fast_osc_run & stable_ff & nxt_fast_on;

   // divide by 1 up to 64
   fast_clock_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .fast_edge(fast_edge & fast_live),
      .ratio_sel(sel_ff),
      .div_tick(div_tick)
   );

   // slow sub clock from the slow RC edges
   assign sys_src_tick = (sel_ff == `SEL_SLOW_SUB) ? slow_edge
                                                  : div_tick;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slow_osc_run <= 1'b1;
         cpu_clock_en <= 1'b0;
         system_clock_en <= 1'b0;
         system_tick <= 1'b0;
         fast_clock_en <= 1'b0;
         fast_clock_tick <= 1'b0;
         slow_sub_clock_en <= 1'b0;
         slow_sub_clock_tick <= 1'b0;
         wdt_clock_tick <= 1'b0;
         timebase_clock_tick <= 1'b0;
         op_mode <= `MODE_FAST;
      end
      else
      begin
         slow_osc_run <= nxt_slow_osc_on;
         cpu_clock_en <= running;
         system_clock_en <= nxt_sys_on;
         // system tick from the selected source
         system_tick <= nxt_sys_on & sys_src_tick;
         fast_clock_en <= fast_live;
         fast_clock_tick <= fast_live & fast_edge;
         slow_sub_clock_en <= nxt_slow_sub_on;
         slow_sub_clock_tick <= nxt_slow_sub_on & slow_edge;
         wdt_clock_tick <= nxt_slow_osc_on & slow_edge;
         timebase_clock_tick <= fast_live ? fast_edge
                                         : nxt_slow_sub_on & slow_edge;
         op_mode <= mode_ff;
      end
   end

endmodule // system_clock_and_power_modes

// ==== verification/clk_mode_checker.sv ====
// Concurrent checks on the clock and power mode controller ports
`include "clk_mode_defs.vh"
module clk_mode_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic wdt_enable,
   input wire logic fast_osc_run,
   input wire logic [1:0] fast_osc_trim_sel,
   input wire logic [3:0] fast_clock_mhz,
   input wire logic slow_osc_run,
   input wire logic cpu_clock_en,
   input wire logic system_clock_en,
   input wire logic system_tick,
   input wire logic fast_clock_en,
   input wire logic fast_clock_tick,
   input wire logic slow_sub_clock_en,
   input wire logic [2:0] op_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic live_ff;
   // ----
   // Checks
   // ----
   // Skips the first edge after reset release
   always @(posedge aclk)
      live_ff <= aresetn;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_cpu_gate:
   assert property (live_ff |-> cpu_clock_en == (op_mode <= `MODE_SLOW))
      else $error("cpu clock gate disagrees with mode");
   a_sleep_gates:
   assert property (op_mode == `MODE_SLEEP
      |-> !(fast_clock_en || slow_sub_clock_en || system_clock_en))
      else $error("clock still on in sleep");
   a_sleep_slow_osc:
   assert property (op_mode == `MODE_SLEEP && $stable(wdt_enable)
      |-> slow_osc_run == wdt_enable)
      else $error("slow oscillator run differs from watchdog in sleep");
   a_idle_slow_only:
   assert property (op_mode == `MODE_IDLE_SLOW_ONLY
      |-> !fast_clock_en && slow_sub_clock_en)
      else $error("wrong gates in slow-only idle");
   a_idle_both:
   assert property (op_mode == `MODE_IDLE_BOTH_CLOCKS
      |-> fast_osc_run && slow_sub_clock_en && system_clock_en)
      else $error("wrong gates in full idle");
   a_idle_fast_only:
   assert property (op_mode == `MODE_IDLE_FAST_ONLY
      |-> fast_osc_run && !slow_sub_clock_en)
      else $error("wrong gates in fast-only idle");
   a_halt_entry:
   assert property (live_ff && halt_req && op_mode <= `MODE_SLOW
      |-> ##2 (op_mode >= `MODE_SLEEP && !cpu_clock_en))
      else $error("halt did not stop the cpu");
   a_halt_hold:
   assert property (live_ff && op_mode >= `MODE_SLEEP && !wake_req
      && !$past(wake_req) |=> $stable(op_mode))
      else $error("halted mode left without wake");
   a_freq_codes:
   assert property (live_ff && $changed(fast_clock_mhz)
      |-> fast_clock_mhz inside {4'h4, 4'h8, 4'hc})
      else $error("illegal fast clock frequency");
   a_settle_first:
   assert property (live_ff && $changed(fast_osc_trim_sel)
      |=> $stable(fast_clock_mhz) [*8])
      else $error("frequency changed before settling");
   a_sys_tick_gate:
   assert property (!system_clock_en && !$past(system_clock_en)
      |-> !system_tick)
      else $error("system tick while gated");
   a_fast_tick_gate:
   assert property (!fast_clock_en && !$past(fast_clock_en)
      |-> !fast_clock_tick)
      else $error("fast tick while gated");
endmodule // clk_mode_checker

bind system_clock_and_power_modes clk_mode_checker u_chk (.aclk, .aresetn,
   .halt_req, .wake_req, .wdt_enable, .fast_osc_run, .fast_osc_trim_sel,
   .fast_clock_mhz, .slow_osc_run, .cpu_clock_en, .system_clock_en,
   .system_tick, .fast_clock_en, .fast_clock_tick, .slow_sub_clock_en,
   .op_mode);

// ==== verification/testbench.sv ====
// Self-checking bench for the clock and power mode controller
`include "clk_mode_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] sc_a = `ADDR_SYS_CLOCK_CTRL;
   localparam logic [7:0] fo_a = `ADDR_FAST_OSC_CTRL;
   localparam logic [7:0] md_a = `ADDR_MODE_STATUS;
   localparam logic [1:0] ok = `RESP_OKAY;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic halt_req, wake_req, wdt_enable;
   logic fast_osc_tick_pin, slow_osc_tick_pin;
   logic fast_osc_run, slow_osc_run, cpu_clock_en, system_clock_en;
   logic system_tick, fast_clock_en, fast_clock_tick, slow_sub_clock_en;
   logic slow_sub_clock_tick, wdt_clock_tick, timebase_clock_tick;
   logic [7:0] awaddr, araddr, pin_cnt;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, fast_clock_mhz;
   logic [1:0] bresp, rresp, fast_osc_trim_sel, k;
   logic [2:0] op_mode, sel;
   integer seed = 24;
   int errors = 0, cmp_count = 0, i, ex;
   int tk [5];

   system_clock_and_power_modes uut (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .halt_req, .wake_req, .wdt_enable, .fast_osc_tick_pin,
      .slow_osc_tick_pin, .fast_osc_run, .fast_osc_trim_sel,
      .fast_clock_mhz, .slow_osc_run, .cpu_clock_en, .system_clock_en,
      .system_tick, .fast_clock_en, .fast_clock_tick, .slow_sub_clock_en,
      .slow_sub_clock_tick, .wdt_clock_tick, .timebase_clock_tick,
      .op_mode);

   // ----
   // Clock and oscillator pins
   // ----
   always #2 aclk = ~aclk;
   always @(posedge aclk)
   begin
      pin_cnt <= pin_cnt + 8'h01;
      fast_osc_tick_pin <= pin_cnt[1];
      slow_osc_tick_pin <= pin_cnt[5];
   end

   // ----
   // Helpers
   // ----
   task automatic finish_test;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic give_up;
      errors++;
      finish_test();
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic int near(input int got, input int e);
      return (got + 1 >= e && got <= e + 1) ? e : got;
   endfunction

   function automatic logic [3:0] mhz_of(input logic [1:0] c);
      return (c == 2'h1) ? 4'h8 : (c == 2'h2) ? 4'hc : 4'h4;
   endfunction

   function automatic logic [2:0] halt_mode(input logic [1:0] kp);
      return (kp == 2'h0) ? `MODE_SLEEP : (kp == 2'h1) ? `MODE_IDLE_SLOW_ONLY
         : (kp == 2'h3) ? `MODE_IDLE_BOTH_CLOCKS : `MODE_IDLE_FAST_ONLY;
   endfunction

   // Write with random ignored upper data and upper strobes
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er);
      logic [31:0] rnd;
      logic aw_ok, w_ok, done;
      int n;
      @(posedge aclk);
      rnd = $random(seed);
      awaddr <= a;
      wdata <= {rnd[31:8], d};
      wstrb <= rnd[3:0] | 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n++)
      begin
         @(negedge aclk);
         aw_ok = awvalid & awready;
         w_ok = wvalid & wready;
         done = bvalid;
         rnd[1:0] = bresp;
         @(posedge aclk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end
      if (!done) give_up();
      check(rnd[1:0], er);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er, output logic [31:0] d);
      logic ar_ok, done;
      logic [1:0] rr;
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n++)
      begin
         @(negedge aclk);
         ar_ok = arvalid & arready;
         done = rvalid;
         d = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ar_ok) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end
      if (!done) give_up();
      if (e !== 32'hffff_ffff) check(d, e);
      check(rr, er);
   endtask

   task automatic wait_stable;
      logic [31:0] v;
      int n;
      v = '0;
      for (n = 0; n < 3000 && !v[`FOC_STABLE]; n++)
         rd_chk(fo_a, 32'hffff_ffff, ok, v);
      if (!v[`FOC_STABLE]) give_up();
   endtask

   task automatic count_ticks(input int cyc);
      logic [4:0] tv;
      tk = '{default: 0};
      repeat (cyc)
      begin
         @(negedge aclk);
         tv = {timebase_clock_tick, wdt_clock_tick, slow_sub_clock_tick,
            fast_clock_tick, system_tick};
         foreach (tk[j]) tk[j] += tv[j];
      end
   endtask

   task automatic pulse(input bit wk);
      @(posedge aclk);
      {wake_req, halt_req} <= wk ? 2'b10 : 2'b01;
      @(posedge aclk);
      {wake_req, halt_req} <= 2'b00;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   // ----
   // Main sequence
   // ----
   initial
   begin
      logic [31:0] v;
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {halt_req, wake_req, wdt_enable, fast_osc_tick_pin} = '0;
      {awaddr, araddr, wdata, wstrb, slow_osc_tick_pin} = '0;
      pin_cnt = 8'h00;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(sc_a, 32'h0000_0000, ok, v);
      rd_chk(fo_a, 32'h0000_0001, ok, v);
      rd_chk(md_a, `MODE_FAST, ok, v);
      rd_chk(8'h0c, 32'h0000_0000, `RESP_DECERR, v);
      axi_wr(8'h0c, 8'hff, `RESP_DECERR);
      wait_stable;
      check(fast_clock_mhz, 4'h4);
      for (i = 1; i < 4; i++)
      begin
         axi_wr(fo_a, {4'h0, i[1:0], 2'h1}, ok);
         rd_chk(fo_a, {i[1:0], 2'h1}, ok, v);
         check(fast_clock_mhz, mhz_of(2'(i - 1)));
         wait_stable;
         check(fast_clock_en, 1'b1);
         check(fast_clock_mhz, mhz_of(i[1:0]));
         check(fast_osc_trim_sel, i[1:0]);
      end
      for (i = 0; i < 7; i++)
      begin
         axi_wr(sc_a, {i[2:0], 5'h00}, ok);
         count_ticks(64);
         count_ticks(1024);
         ex = tk[1] >> i;
         check(near(tk[0], ex), ex);
         check(tk[4] > 0, 1);
      end
      axi_wr(sc_a, 8'he0, ok);
      count_ticks(64);
      count_ticks(1024);
      check(op_mode, `MODE_SLOW);
      check(near(tk[0], tk[2]), tk[2]);
      check(near(tk[2], 16), 16);
      check(tk[3] > 0, 1);
      axi_wr(fo_a, 8'h0c, ok);
      repeat (3) @(negedge aclk);
      check(fast_osc_run, 1'b0);
      axi_wr(fo_a, 8'h0d, ok);
      rd_chk(fo_a, 32'h0000_000d, ok, v);
      check(fast_osc_run, 1'b1);
      wait_stable;
      count_ticks(256);
      check(tk[1] > 0, 1);
      for (i = 0; i < 8; i++)
      begin
         k = i[2:1];
         sel = i[0] ? 3'h7 : 3'({$random(seed)} % 7);
         wdt_enable <= i[0];
         axi_wr(sc_a, {sel, 3'h0, k}, ok);
         wait_stable;
         pulse(1'b0);
         check(op_mode, halt_mode(k));
         check(cpu_clock_en, 1'b0);
         check(system_clock_en, k[1] ? (k[0] || !i[0]) : k[0] && i[0]);
         check(slow_sub_clock_en, k[0]);
         if (k == 2'h0) check(slow_osc_run, i[0]);
         rd_chk(md_a, halt_mode(k), ok, v);
         pulse(1'b0);
         check(op_mode, halt_mode(k));
         pulse(1'b1);
         check(op_mode, i[0] ? `MODE_SLOW : `MODE_FAST);
      end
      finish_test();
   end
endmodule // testbench
